//--- common/scr_defines.svh
// Offsets, field positions, reset values and codes for the channel reconfiguration block
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH
// Register indices (byte address is four times the index)
`define SCR_IDX_STATION 10'h24F
`define SCR_IDX_CH1_PROTO 10'h252
`define SCR_IDX_CH1_TX 10'h253
`define SCR_IDX_CH2_PROTO 10'h262
`define SCR_IDX_CH2_TX 10'h263
`define SCR_IDX_EXEC_TYPE 10'h300
`define SCR_IDX_CH1_TX_SET 10'h301
`define SCR_IDX_CH1_PROTO_SET 10'h302
`define SCR_IDX_CH2_TX_SET 10'h303
`define SCR_IDX_CH2_PROTO_SET 10'h304
`define SCR_IDX_STATION_SET 10'h305
`define SCR_IDX_COMMAND 10'h306
`define SCR_IDX_RESULT 10'h307
`define SCR_IDX_FLAGS 10'h308
// Command word fields
`define SCR_CMD_START_BIT 0
`define SCR_CMD_IO_LSB 8
`define SCR_CMD_IO_MSB 15
// Flags word fields
`define SCR_FLAG_DONE_BIT 0
`define SCR_FLAG_ERR_BIT 1
`define SCR_FLAG_BUSY_BIT 2
// Value limits
`define SCR_PROTO_MAX 4'h9
`define SCR_STATION_MAX 5'h1F
`define SCR_EXEC_APPLY 16'h0000
`define SCR_EXEC_RESTORE 16'h0001
// Protocol codes treated as slave modes of the field bus
`define SCR_PROTO_FB_SLAVE_RTU 4'h7
`define SCR_PROTO_FB_SLAVE_ASCII 4'h8
`define SCR_FW_SLAVE_CHANGE_REV 8'h0D
// Engineering-tool user parameter settings and reset values
`define SCR_USR_CH1_TX 12'h000
`define SCR_USR_CH1_PROTO 4'h0
`define SCR_USR_CH2_TX 12'h000
`define SCR_USR_CH2_PROTO 4'h0
`define SCR_USR_STATION 5'h00
// Result codes
`define SCR_ERR_NONE 16'h0000
`define SCR_ERR_CONCURRENT 16'h7FF0
`define SCR_ERR_MODE_CONFLICT 16'h7FF5
`define SCR_ERR_NO_PERMIT 16'h7F01
`define SCR_ERR_EXEC_TYPE 16'h7F02
`define SCR_ERR_RANGE 16'h7F03
`define SCR_ERR_SLAVE_PROTO 16'h7F04
// Bus responses
`define SCR_RESP_OKAY 2'h0
`define SCR_RESP_SLVERR 2'h2
`endif

//--- common/scr_pkg.sv
// Types for the channel reconfiguration block
package scr_pkg;
    typedef enum logic [2:0] {
        SCR_IDLE = 3'b001,
        SCR_WAIT = 3'b010,
        SCR_FLAG = 3'b100
    } scr_state_type;
    typedef logic [3:0] scr_proto_type;
    typedef logic [11:0] scr_tx_type;
    typedef logic [4:0] scr_station_type;
endpackage : scr_pkg

//--- hw/scr_check.sv
// Request check and settings selection for a reconfiguration
`include "scr_defines.svh"
module scr_check
    import scr_pkg::*;
#(
    parameter logic [7:0] FW_REV = 8'h0D
)
(
    input wire logic [15:0] exec_type_i,
    input wire logic [15:0] ch1_tx_set_i,
    input wire logic [15:0] ch1_proto_set_i,
    input wire logic [15:0] ch2_tx_set_i,
    input wire logic [15:0] ch2_proto_set_i,
    input wire logic [15:0] station_set_i,
    input wire scr_proto_type cur_proto_i [2],
    input wire logic [1:0] op_active_i,
    input wire logic [1:0] mode_change_request_signal_i,
    input wire logic perm_set_i,
    input wire logic perm_allow_i,
    output logic [15:0] err_code_o,
    output scr_tx_type new_tx_o [2],
    output scr_proto_type new_proto_o [2],
    output scr_station_type new_station_o
);
    logic restore;
    logic range_bad;
    logic slave_bad;

    function automatic logic is_slave(input scr_proto_type p);
        is_slave = (p == `SCR_PROTO_FB_SLAVE_RTU) || (p == `SCR_PROTO_FB_SLAVE_ASCII);
    endfunction : is_slave

    // Chosen settings: given values or tool defaults
    // apply or restore
    assign restore = (exec_type_i == `SCR_EXEC_RESTORE);
    assign new_tx_o[0] = restore ? `SCR_USR_CH1_TX : ch1_tx_set_i[11:0];
    assign new_tx_o[1] = restore ? `SCR_USR_CH2_TX : ch2_tx_set_i[11:0];
    assign new_proto_o[0] = restore ? `SCR_USR_CH1_PROTO : ch1_proto_set_i[3:0];
    assign new_proto_o[1] = restore ? `SCR_USR_CH2_PROTO : ch2_proto_set_i[3:0];
    assign new_station_o = restore ? `SCR_USR_STATION : station_set_i[4:0];

    assign range_bad = !restore && ((ch1_tx_set_i[15:12] != 4'h0) || (ch2_tx_set_i[15:12] != 4'h0)
        || (ch1_proto_set_i > {12'h000, `SCR_PROTO_MAX}) || (ch2_proto_set_i > {12'h000, `SCR_PROTO_MAX})
        || (station_set_i > {11'h000, `SCR_STATION_MAX}));

    assign slave_bad = (FW_REV < `SCR_FW_SLAVE_CHANGE_REV)
        && (((new_proto_o[0] != cur_proto_i[0]) && (is_slave(new_proto_o[0]) || is_slave(cur_proto_i[0])))
        || ((new_proto_o[1] != cur_proto_i[1]) && (is_slave(new_proto_o[1]) || is_slave(cur_proto_i[1]))));

    // Error priority, first match wins
    always_comb
    begin
        if (op_active_i != 2'b00)
            err_code_o = `SCR_ERR_CONCURRENT;
        else if (mode_change_request_signal_i != 2'b00)
            err_code_o = `SCR_ERR_MODE_CONFLICT;
        else if (perm_set_i && !perm_allow_i)
            err_code_o = `SCR_ERR_NO_PERMIT;
        else if ((exec_type_i != `SCR_EXEC_APPLY) && !restore)
            err_code_o = `SCR_ERR_EXEC_TYPE;
        else if (range_bad)
            err_code_o = `SCR_ERR_RANGE;
        else if (slave_bad)
            err_code_o = `SCR_ERR_SLAVE_PROTO;
        else
            err_code_o = `SCR_ERR_NONE;
    end
endmodule : scr_check

//--- hw/scr_core.sv
// Two-channel serial reconfiguration handler with AXI4-Lite register access
//
// What this block does
// - Apply new settings to addressed module's channels
// - Done flag set, cleared at scan ends
// - Error flag pulses one scan on failure
// - Abort reception, discard receive data
// - Abort transmission at acceptance
// - Drop modem line on request
// - Conflicting operation yields concurrent error
// - Second request ignored while one active
// - Needs change permission; unset means permitted
// - Mode change signal conflict reports error
// - Protocol and transmission status readable
// - Station number status readable
// - Old firmware refuses slave protocol changes
// - Result word zero or error code
// - Type 0 applies, 1 restores
// - Field ranges: twelve bits, 0-9, 0-31
`include "scr_defines.svh"
module scr_core
    import scr_pkg::*;
#(
    parameter logic [7:0] IO_NUMBER = 8'h00,
    parameter logic [7:0] FW_REV = 8'h0D
)
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scan_end_i,
    input wire logic [1:0] op_active_i,
    input wire logic [1:0] mode_change_request_signal_i,
    input wire logic [1:0] modem_link_i,
    input wire logic perm_set_i,
    input wire logic perm_allow_i,
    output logic done_o,
    output logic error_o,
    output logic reconfig_busy_o,
    output logic [1:0] rx_abort_o,
    output logic [1:0] tx_abort_o,
    output logic [1:0] line_cut_o
);
    scr_state_type state_reg;
    logic [11:0] awaddr_reg;
    logic aw_full_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_full_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic write_fire;
    logic [9:0] widx;
    logic [9:0] ridx;
    logic w_mapped;
    logic r_mapped;
    logic [31:0] rd_word;
    logic [15:0] exec_type_reg;
    logic [15:0] ch1_tx_set_reg;
    logic [15:0] ch1_proto_set_reg;
    logic [15:0] ch2_tx_set_reg;
    logic [15:0] ch2_proto_set_reg;
    logic [15:0] station_set_reg;
    logic [15:0] result_reg;
    logic done_reg;
    logic error_reg;
    logic start_req;
    logic accept;
    logic [15:0] err_code;
    scr_tx_type new_tx [2];
    scr_proto_type new_proto [2];
    scr_station_type new_station;
    scr_tx_type tx_stat_reg [2];
    scr_proto_type proto_stat_reg [2];
    scr_station_type station_stat_reg;
    logic [1:0] rx_abort_reg;
    logic [1:0] tx_abort_reg;
    logic [1:0] line_cut_reg;

    // Byte-lane merge of a 16-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // Write channel handshakes
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign write_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign widx = awaddr_reg[11:2];
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Address and data holding, either order
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end
            else if (write_fire)
                aw_full_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
            end
            else if (write_fire)
                w_full_reg <= 1'b0;
        end
    end

    // Write decode: every defined index answers OKAY
    always_comb
    begin
        case (widx)
            `SCR_IDX_STATION, `SCR_IDX_CH1_PROTO, `SCR_IDX_CH1_TX, `SCR_IDX_CH2_PROTO, `SCR_IDX_CH2_TX,
            `SCR_IDX_EXEC_TYPE, `SCR_IDX_CH1_TX_SET, `SCR_IDX_CH1_PROTO_SET, `SCR_IDX_CH2_TX_SET,
            `SCR_IDX_CH2_PROTO_SET, `SCR_IDX_STATION_SET, `SCR_IDX_COMMAND, `SCR_IDX_RESULT,
            `SCR_IDX_FLAGS: w_mapped = 1'b1;
            default: w_mapped = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `SCR_RESP_OKAY;
        end
        else if (write_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= w_mapped ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    // Control block words written by software
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            exec_type_reg <= 16'h0000;
            ch1_tx_set_reg <= 16'h0000;
            ch1_proto_set_reg <= 16'h0000;
            ch2_tx_set_reg <= 16'h0000;
            ch2_proto_set_reg <= 16'h0000;
            station_set_reg <= 16'h0000;
        end
        else if (write_fire)
        begin
            case (widx)
                `SCR_IDX_EXEC_TYPE: exec_type_reg <= merge16(exec_type_reg, wdata_reg, wstrb_reg);
                `SCR_IDX_CH1_TX_SET: ch1_tx_set_reg <= merge16(ch1_tx_set_reg, wdata_reg, wstrb_reg);
                `SCR_IDX_CH1_PROTO_SET: ch1_proto_set_reg <= merge16(ch1_proto_set_reg, wdata_reg, wstrb_reg);
                `SCR_IDX_CH2_TX_SET: ch2_tx_set_reg <= merge16(ch2_tx_set_reg, wdata_reg, wstrb_reg);
                `SCR_IDX_CH2_PROTO_SET: ch2_proto_set_reg <= merge16(ch2_proto_set_reg, wdata_reg, wstrb_reg);
                `SCR_IDX_STATION_SET: station_set_reg <= merge16(station_set_reg, wdata_reg, wstrb_reg);
                default: ;
            endcase
        end
    end

    // Start command aimed at this module
    // match start I/O number
    assign start_req = write_fire && (widx == `SCR_IDX_COMMAND) && wstrb_reg[0] && wstrb_reg[1]
        && wdata_reg[`SCR_CMD_START_BIT] && (wdata_reg[`SCR_CMD_IO_MSB:`SCR_CMD_IO_LSB] == IO_NUMBER);
    assign accept = start_req && (state_reg == SCR_IDLE);

    scr_check #(
        .FW_REV(FW_REV)
    ) u_check (
        .exec_type_i(exec_type_reg),
        .ch1_tx_set_i(ch1_tx_set_reg),
        .ch1_proto_set_i(ch1_proto_set_reg),
        .ch2_tx_set_i(ch2_tx_set_reg),
        .ch2_proto_set_i(ch2_proto_set_reg),
        .station_set_i(station_set_reg),
        .cur_proto_i(proto_stat_reg),
        .op_active_i(op_active_i),
        .mode_change_request_signal_i(mode_change_request_signal_i),
        .perm_set_i(perm_set_i),
        .perm_allow_i(perm_allow_i),
        .err_code_o(err_code),
        .new_tx_o(new_tx),
        .new_proto_o(new_proto),
        .new_station_o(new_station)
    );

    // Sequencer: accept, wait scan end, flag one scan
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= SCR_IDLE;
            done_reg <= 1'b0;
            error_reg <= 1'b0;
            result_reg <= `SCR_ERR_NONE;
        end
        else
        begin
            case (state_reg)
                SCR_IDLE:
                begin
                    if (accept)
                    begin
                        result_reg <= err_code;
                        state_reg <= SCR_WAIT;
                    end
                end
                SCR_WAIT:
                begin
                    if (scan_end_i)
                    begin
                        done_reg <= 1'b1;
                        error_reg <= (result_reg != `SCR_ERR_NONE);
                        state_reg <= SCR_FLAG;
                    end
                end
                SCR_FLAG:
                begin
                    if (scan_end_i)
                    begin
                        done_reg <= 1'b0;
                        error_reg <= 1'b0;
                        state_reg <= SCR_IDLE;
                    end
                end
                default:
                    state_reg <= SCR_IDLE;
            endcase
        end
    end

    // Station status, shared by the module
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            station_stat_reg <= `SCR_USR_STATION;
        // commit before done; kept on failure
        else if (accept && (err_code == `SCR_ERR_NONE))
            station_stat_reg <= new_station;
    end

    // Per-channel status words and abort strobes
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    tx_stat_reg[ch] <= (ch == 0) ? `SCR_USR_CH1_TX : `SCR_USR_CH2_TX;
                    proto_stat_reg[ch] <= (ch == 0) ? `SCR_USR_CH1_PROTO : `SCR_USR_CH2_PROTO;
                end
                else if (accept && (err_code == `SCR_ERR_NONE))
                begin
                    tx_stat_reg[ch] <= new_tx[ch];
                    proto_stat_reg[ch] <= new_proto[ch];
                end
            end
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    rx_abort_reg[ch] <= 1'b0;
                    tx_abort_reg[ch] <= 1'b0;
                    line_cut_reg[ch] <= 1'b0;
                end
                else
                begin
                    rx_abort_reg[ch] <= accept;
                    tx_abort_reg[ch] <= accept;
                    line_cut_reg[ch] <= accept && modem_link_i[ch];
                end
            end
        end
    endgenerate

    assign done_o = done_reg;
    assign error_o = error_reg;
    // busy level lets other operations fail
    assign reconfig_busy_o = (state_reg != SCR_IDLE);
    assign rx_abort_o = rx_abort_reg;
    assign tx_abort_o = tx_abort_reg;
    assign line_cut_o = line_cut_reg;

    // Read decode and word mux
    assign ridx = s_axi_araddr[11:2];
    always_comb
    begin
        r_mapped = 1'b1;
        case (ridx)
            `SCR_IDX_STATION: rd_word = {27'h0000000, station_stat_reg};
            `SCR_IDX_CH1_PROTO: rd_word = {28'h0000000, proto_stat_reg[0]};
            `SCR_IDX_CH1_TX: rd_word = {20'h00000, tx_stat_reg[0]};
            `SCR_IDX_CH2_PROTO: rd_word = {28'h0000000, proto_stat_reg[1]};
            `SCR_IDX_CH2_TX: rd_word = {20'h00000, tx_stat_reg[1]};
            `SCR_IDX_EXEC_TYPE: rd_word = {16'h0000, exec_type_reg};
            `SCR_IDX_CH1_TX_SET: rd_word = {16'h0000, ch1_tx_set_reg};
            `SCR_IDX_CH1_PROTO_SET: rd_word = {16'h0000, ch1_proto_set_reg};
            `SCR_IDX_CH2_TX_SET: rd_word = {16'h0000, ch2_tx_set_reg};
            `SCR_IDX_CH2_PROTO_SET: rd_word = {16'h0000, ch2_proto_set_reg};
            `SCR_IDX_STATION_SET: rd_word = {16'h0000, station_set_reg};
            `SCR_IDX_COMMAND: rd_word = 32'h0000_0000;
            `SCR_IDX_RESULT: rd_word = {16'h0000, result_reg};
            `SCR_IDX_FLAGS: rd_word = {29'h00000000, reconfig_busy_o, error_reg, done_reg};
            default:
            begin
                rd_word = 32'h0000_0000;
                r_mapped = 1'b0;
            end
        endcase
    end

    // Read channel
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SCR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= r_mapped ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end
endmodule : scr_core

//--- test/scr_core_props.sv
// Flag, abort and read checks on the reconfiguration block ports
module scr_core_props
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic scan_end_i,
    input wire logic done_o,
    input wire logic error_o,
    input wire logic reconfig_busy_o,
    input wire logic [1:0] rx_abort_o,
    input wire logic [1:0] tx_abort_o,
    input wire logic [1:0] line_cut_o,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Flag window and pulses
    AST_DONE_RISE: assert property ($rose(done_o) |-> $past(scan_end_i))
        else $error("done rose off scan end");
    AST_DONE_FALL: assert property (done_o && scan_end_i |=> !done_o && !error_o)
        else $error("flags held past scan end");
    AST_ERR_IN_DONE: assert property (error_o |-> done_o)
        else $error("error without done");
    AST_DONE_BUSY: assert property (done_o |-> reconfig_busy_o)
        else $error("done while idle");
    AST_BUSY_SPAN: assert property (reconfig_busy_o && !(done_o && scan_end_i) |=> reconfig_busy_o)
        else $error("busy dropped early");
    AST_ABORT: assert property ($rose(reconfig_busy_o) |-> ##[0:1] (rx_abort_o == 2'b11 && tx_abort_o == 2'b11))
        else $error("no abort on acceptance");
    AST_ABORT_PULSE: assert property (rx_abort_o != 2'b00 |=> rx_abort_o == 2'b00 && tx_abort_o == 2'b00)
        else $error("abort longer than one cycle");
    AST_CUT: assert property ((line_cut_o & ~rx_abort_o) == 2'b00)
        else $error("line cut off acceptance");
    AST_RANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule : scr_core_props
bind scr_core scr_core_props scr_core_props_inst (.*);

//--- test/scr_far_dev.sv
// Far serial device model: modem line per channel
module scr_far_dev
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [1:0] dial_i,
    input wire logic [1:0] line_cut_i,
    output logic [1:0] link_o
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            link_o <= 2'b00;
        else
            link_o <= (link_o | dial_i) & ~line_cut_i;
    end
endmodule : scr_far_dev

//--- test/testbench.sv
// Self-checking bench for the channel reconfiguration block
`include "scr_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, srst_i, scan_end_i, perm_set_i, perm_allow_i, done_o, error_o, reconfig_busy_o;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, r32;
    logic [31:0] rnd_state = 32'h7D7B4268;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, dial, op_active_i, mode_change_request_signal_i;
    logic [1:0] modem_link_i, rx_abort_o, tx_abort_o, line_cut_o;
    logic [15:0] cfg [6];
    logic [15:0] st_exp [5];
    logic [9:0] st_idx [5] = '{`SCR_IDX_STATION, `SCR_IDX_CH1_PROTO, `SCR_IDX_CH1_TX, `SCR_IDX_CH2_PROTO,
        `SCR_IDX_CH2_TX};
    int failures, n_compared;
    scr_core #(.FW_REV(8'h0C)) scr_core_inst (.*); // Older firmware: slave changes refused
    scr_far_dev scr_far_dev_inst (.clk_i, .srst_i, .dial_i(dial), .line_cut_i(line_cut_o), .link_o(modem_link_i));
    // Clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Xorshift stimulus source
    function automatic logic [31:0] rnd();
        rnd_state = rnd_state ^ (rnd_state << 13);
        rnd_state = rnd_state ^ (rnd_state >> 17);
        rnd_state = rnd_state ^ (rnd_state << 5);
        return rnd_state;
    endfunction : rnd
    // Slave protocol codes
    function automatic logic is_sl(input logic [15:0] p);
        return (p == {12'h000, `SCR_PROTO_FB_SLAVE_RTU}) || (p == {12'h000, `SCR_PROTO_FB_SLAVE_ASCII});
    endfunction : is_sl
    // Expected result code, checks in priority order
    function automatic logic [15:0] exp_code(input logic [1:0] op, md, input logic ps, pa);
        logic [15:0] n1, n2;
        n1 = (cfg[0] == `SCR_EXEC_RESTORE) ? {12'h000, `SCR_USR_CH1_PROTO} : cfg[2];
        n2 = (cfg[0] == `SCR_EXEC_RESTORE) ? {12'h000, `SCR_USR_CH2_PROTO} : cfg[4];
        if (op != 2'b00)
            return `SCR_ERR_CONCURRENT;
        if (md != 2'b00)
            return `SCR_ERR_MODE_CONFLICT;
        if (ps && !pa)
            return `SCR_ERR_NO_PERMIT;
        if (cfg[0] > `SCR_EXEC_RESTORE)
            return `SCR_ERR_EXEC_TYPE;
        if (cfg[0] == `SCR_EXEC_APPLY && (cfg[2] > 16'h0009 || cfg[4] > 16'h0009 || cfg[5] > 16'h001F))
            return `SCR_ERR_RANGE;
        if ((n1 != st_exp[1] && (is_sl(n1) || is_sl(st_exp[1])))
            || (n2 != st_exp[3] && (is_sl(n2) || is_sl(st_exp[3]))))
            return `SCR_ERR_SLAVE_PROTO;
        return `SCR_ERR_NONE;
    endfunction : exp_code
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        logic a, w, b;
        @(posedge clk_i);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b)
        begin
            @(negedge clk_i);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge clk_i);
            if (a)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            if (b)
                s_axi_bready <= 1'b0;
        end
    endtask : wr
    task automatic rd_reg(input logic [9:0] idx);
        logic a, r;
        @(posedge clk_i);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 1'b0;
        while (!r)
        begin
            @(negedge clk_i);
            a = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_i);
            if (a)
                s_axi_arvalid <= 1'b0;
            if (r)
                s_axi_rready <= 1'b0;
        end
    endtask : rd_reg
    task automatic set_defaults();
        st_exp = '{{11'h000, `SCR_USR_STATION}, {12'h000, `SCR_USR_CH1_PROTO}, {4'h0, `SCR_USR_CH1_TX},
            {12'h000, `SCR_USR_CH2_PROTO}, {4'h0, `SCR_USR_CH2_TX}};
    endtask : set_defaults
    task automatic check_status();
        for (int k = 0; k < 5; k++)
        begin
            rd_reg(st_idx[k]);
            chk(rd, {16'h0000, st_exp[k]});
        end
    endtask : check_status
    task automatic scan(input logic ed, input logic ee);
        @(posedge clk_i);
        scan_end_i <= 1'b1;
        @(posedge clk_i);
        scan_end_i <= 1'b0;
        @(negedge clk_i);
        chk({done_o, error_o, reconfig_busy_o}, {ed, ee, ed});
    endtask : scan
    // One reconfiguration, conflict kind chosen by trial number
    task automatic trial(input int i);
        logic [15:0] code;
        logic [1:0] op, md;
        logic ps, pa;
        r32 = rnd();
        cfg[0] = `SCR_EXEC_APPLY;
        cfg[1] = {4'h0, r32[11:0]};
        cfg[3] = {4'h0, r32[23:12]};
        cfg[2] = {12'h000, r32[27:24] % 4'hA};
        cfg[4] = {12'h000, r32[31:28] % 4'hA};
        r32 = rnd();
        cfg[5] = {11'h000, r32[4:0]};
        op = 2'b00;
        md = 2'b00;
        ps = r32[5];
        pa = r32[5] | r32[6];
        case (i % 7)
            1: op = i[0] ? 2'b10 : 2'b01;
            2: md = i[0] ? 2'b10 : 2'b01;
            3: ps = 1'b1;
            4: cfg[0] = 16'h0002 + 16'(i);
            5: cfg[i[0] ? 5 : 2] = i[0] ? 16'h0020 : 16'h000A;
            6: cfg[0] = `SCR_EXEC_RESTORE;
            default: ;
        endcase
        if (i % 7 == 3)
            pa = 1'b0;
        code = exp_code(op, md, ps, pa);
        @(posedge clk_i);
        op_active_i <= op;
        mode_change_request_signal_i <= md;
        perm_set_i <= ps;
        perm_allow_i <= pa;
        dial <= r32[8:7];
        @(posedge clk_i);
        dial <= 2'b00;
        for (int k = 0; k < 6; k++)
            wr(`SCR_IDX_EXEC_TYPE + 10'(k), cfg[k]);
        wr(`SCR_IDX_COMMAND, 16'h0001);
        op_active_i <= 2'b00;
        mode_change_request_signal_i <= 2'b00;
        rd_reg(`SCR_IDX_RESULT);
        chk(rd, {16'h0000, code});
        chk(modem_link_i, 2'b00);
        if (code == `SCR_ERR_NONE && cfg[0] == `SCR_EXEC_RESTORE)
            set_defaults();
        else if (code == `SCR_ERR_NONE)
            st_exp = '{cfg[5], cfg[2], cfg[1], cfg[4], cfg[3]};
        check_status();
        scan(1'b1, code != `SCR_ERR_NONE);
        wr(`SCR_IDX_COMMAND, 16'h0001);
        scan(1'b0, 1'b0);
        check_status();
    endtask : trial
    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk_i);
        failures++;
        stop_test();
    end
    // Main sequence
    initial
    begin
        {scan_end_i, perm_set_i, perm_allow_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
        {s_axi_arvalid, s_axi_rready, dial, op_active_i, mode_change_request_signal_i} = 8'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        srst_i = 1'b1;
        set_defaults();
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        check_status();
        rd_reg(10'h000);
        chk(resp, `SCR_RESP_SLVERR);
        wr(`SCR_IDX_CH1_TX, 16'h0ABC);
        chk(resp, `SCR_RESP_OKAY);
        wr(`SCR_IDX_COMMAND, 16'h0101);
        @(negedge clk_i);
        chk(reconfig_busy_o, 1'b0);
        check_status();
        for (int i = 0; i < 21; i++)
            trial(i);
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        set_defaults();
        check_status();
        stop_test();
    end
endmodule : testbench
